/* File: src/twm_master.sv */
// Two-wire bus master that writes and reads byte registers of a slave.
// Assumes open-drain pins resolved outside; write bytes come through the FIFO.
`timescale 1ns/1ps
`include "twm_defs.svh"
module twm_master (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic cmdRead,
   input wire logic cmdSelect,
   input wire logic [7:0] cmdRegAddr,
   input wire logic [7:0] cmdCount,
   input wire logic [7:0] wrData,
   input wire logic wrValid,
   output logic wrReady,
   output logic [7:0] rdData,
   output logic rdValid,
   output logic done,
   output logic nackErr,
   output logic busy,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe
);
   localparam logic [7:0] QMAX = 8'(`TWM_QUARTER_CYC - 1);

   twm_pkg::twm_state_e state, next_state;
   twm_pkg::twm_step_e step;
   logic [7:0] divCnt, txByte, rxByte, regAddrL, remaining;
   logic [1:0] quarter;
   logic [2:0] bitIdx;
   logic isRead, sel, regSent;
   logic sclMeta, sclSync, sdaMeta, sdaSync;
   logic tick, adv, qEnd, accept, ackEnd, ackOk, rxMode, lastByte, nackEvt;
   logic fifoValid, fifoPop;
   logic [7:0] fifoData;

   function automatic logic [7:0] slaveByte(input logic s, input logic rd);
      slaveByte = {`TWM_SLAVE_ADDR_HI, s, rd};
   endfunction

   twm_fifo #(.WIDTH(`TWM_BYTE_W), .DEPTH(`TWM_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(wrValid),
      .inReady(wrReady),
      .inData(wrData),
      .outValid(fifoValid),
      .outReady(fifoPop),
      .outData(fifoData)
   );

   assign tick = divCnt == QMAX;
   // Wait for the released clock to read high (stretching)
   assign adv = tick && !(quarter == 2'd3 && !sclSync);
   assign qEnd = adv && quarter == 2'd3;
   assign accept = cmdValid && cmdReady;
   assign ackEnd = qEnd && state == twm_pkg::S_ACK;
   assign ackOk = !sdaSync;
   assign rxMode = isRead && step == twm_pkg::ST_DATA;
   assign lastByte = remaining == 8'h01;
   assign nackEvt = ackEnd && !rxMode && !ackOk;
   assign fifoPop = state == twm_pkg::S_LOAD;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclMeta <= 1'b1;
         sclSync <= 1'b1;
         sdaMeta <= 1'b1;
         sdaSync <= 1'b1;
      end else begin
         sclMeta <= sclIn;
         sclSync <= sclMeta;
         sdaMeta <= sdaIn;
         sdaSync <= sdaMeta;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt <= 8'h00;
      end else begin
         divCnt <= tick ? 8'h00 : divCnt + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      unique case (state)
         twm_pkg::S_IDLE: if (accept) next_state = twm_pkg::S_START;
         twm_pkg::S_START: if (qEnd) next_state = twm_pkg::S_SHIFT;
         twm_pkg::S_SHIFT: if (qEnd && bitIdx == 3'd7) next_state = twm_pkg::S_ACK;
         twm_pkg::S_LOAD: if (fifoValid) next_state = twm_pkg::S_SHIFT;
         twm_pkg::S_STOP: if (qEnd) next_state = twm_pkg::S_IDLE;
         twm_pkg::S_ACK: begin
            if (qEnd) begin
               unique case (step)
                  twm_pkg::ST_ADDR_W, twm_pkg::ST_ADDR_R:
                     next_state = ackOk ? twm_pkg::S_SHIFT : twm_pkg::S_STOP;
                  twm_pkg::ST_REG: begin
                     if (!ackOk || (!isRead && remaining == 8'h00)) begin
                        next_state = twm_pkg::S_STOP;
                     end else if (isRead) begin
                        next_state = twm_pkg::S_START;
                     end else begin
                        next_state = twm_pkg::S_LOAD;
                     end
                  end
                  twm_pkg::ST_DATA: begin
                     if (lastByte || (!isRead && !ackOk)) begin
                        next_state = twm_pkg::S_STOP;
                     end else begin
                        next_state = isRead ? twm_pkg::S_SHIFT : twm_pkg::S_LOAD;
                     end
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= twm_pkg::S_IDLE;
         quarter <= 2'd0;
         bitIdx <= 3'd0;
      end else begin
         state <= next_state;
         if (state == twm_pkg::S_IDLE || state == twm_pkg::S_LOAD) begin
            quarter <= 2'd0;
         end else if (adv) begin
            quarter <= quarter + 2'd1;
         end
         if (qEnd && state == twm_pkg::S_SHIFT) begin
            bitIdx <= bitIdx + 3'd1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         isRead <= 1'b0;
         sel <= 1'b0;
         regAddrL <= 8'h00;
         remaining <= 8'h00;
         step <= twm_pkg::ST_ADDR_W;
         txByte <= 8'hFF;
         rxByte <= 8'h00;
         regSent <= 1'b0;
      end else if (accept) begin
         isRead <= cmdRead;
         sel <= cmdSelect;
         regAddrL <= cmdRegAddr;
         remaining <= (cmdRead && cmdCount == 8'h00) ? 8'h01 : cmdCount;
         step <= twm_pkg::ST_ADDR_W;
         txByte <= slaveByte(cmdSelect, 1'b0);
         regSent <= 1'b0;
      end else if (state == twm_pkg::S_LOAD && fifoValid) begin
         txByte <= fifoData;
      end else if (qEnd && state == twm_pkg::S_SHIFT) begin
         txByte <= {txByte[6:0], 1'b1};
         rxByte <= {rxByte[6:0], sdaSync};
      end else if (ackEnd && (ackOk || rxMode)) begin
         unique case (step)
            twm_pkg::ST_ADDR_W: begin
               step <= twm_pkg::ST_REG;
               txByte <= regAddrL;
            end
            twm_pkg::ST_REG: begin
               regSent <= 1'b1;
               if (isRead) begin
                  step <= twm_pkg::ST_ADDR_R;
                  txByte <= slaveByte(sel, 1'b1);
               end else begin
                  step <= twm_pkg::ST_DATA;
               end
            end
            twm_pkg::ST_ADDR_R: begin
               step <= twm_pkg::ST_DATA;
               txByte <= 8'hFF;
            end
            twm_pkg::ST_DATA: remaining <= remaining - 8'h01;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Quarters: 0 clock low, 1 set data, 2 clock released, 3 sample or edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclOe <= 1'b0;
         sdaOe <= 1'b0;
         sclOut <= 1'b0;
         sdaOut <= 1'b0;
      end else begin
         sclOut <= 1'b0;
         sdaOut <= 1'b0;
         if (adv && state != twm_pkg::S_IDLE && state != twm_pkg::S_LOAD) begin
            unique case (quarter)
               2'd0: sclOe <= 1'b1;
               2'd1: begin
                  unique case (state)
                     twm_pkg::S_START: sdaOe <= 1'b0;
                     twm_pkg::S_STOP: sdaOe <= 1'b1;
                     twm_pkg::S_SHIFT: sdaOe <= rxMode ? 1'b0 : !txByte[7];
                     default: sdaOe <= rxMode ? !lastByte : 1'b0;
                  endcase
               end
               2'd2: sclOe <= 1'b0;
               2'd3: begin
                  if (state == twm_pkg::S_START) begin
                     sdaOe <= 1'b1;
                  end else if (state == twm_pkg::S_STOP) begin
                     sdaOe <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmdReady <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         nackErr <= 1'b0;
         rdValid <= 1'b0;
         rdData <= 8'h00;
      end else begin
         cmdReady <= next_state == twm_pkg::S_IDLE;
         busy <= next_state != twm_pkg::S_IDLE;
         done <= state != twm_pkg::S_IDLE && next_state == twm_pkg::S_IDLE;
         if (nackEvt) begin
            nackErr <= 1'b1;
         end else if (accept) begin
            nackErr <= 1'b0;
         end
         rdValid <= ackEnd && rxMode;
         if (ackEnd && rxMode) begin
            rdData <= rxByte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_idle_release;
      @(posedge clk) disable iff (!rst_n)
      state == twm_pkg::S_IDLE && $past(state) == twm_pkg::S_IDLE |-> !sclOe && !sdaOe && !sclOut && !sdaOut;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("bus driven while idle");

   property p_sda_stable;
      @(posedge clk) disable iff (!rst_n)
      !sclOe && !$past(sclOe) && $changed(sdaOe) |->
         ($past(state) == twm_pkg::S_START || $past(state) == twm_pkg::S_STOP) && $past(quarter) == 2'd3;
   endproperty
   a_sda_stable: assert property (p_sda_stable) else $error("data moved while clock high");

   property p_start_edge;
      @(posedge clk) disable iff (!rst_n)
      $rose(sdaOe) && !sclOe |-> $past(state) == twm_pkg::S_START && state == twm_pkg::S_SHIFT;
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("stray falling data edge");

   property p_stop_edge;
      @(posedge clk) disable iff (!rst_n)
      $fell(sdaOe) && !sclOe |-> state == twm_pkg::S_IDLE && done;
   endproperty
   a_stop_edge: assert property (p_stop_edge) else $error("stray rising data edge");

   property p_addr_byte;
      @(posedge clk) disable iff (!rst_n)
      accept |=> txByte == {`TWM_SLAVE_ADDR_HI, $past(cmdSelect), 1'b0} && state == twm_pkg::S_START;
   endproperty
   a_addr_byte: assert property (p_addr_byte) else $error("bad address byte");

   property p_read_dir;
      @(posedge clk) disable iff (!rst_n)
      $rose(step == twm_pkg::ST_ADDR_R) |-> txByte == {`TWM_SLAVE_ADDR_HI, sel, 1'b1} && isRead;
   endproperty
   a_read_dir: assert property (p_read_dir) else $error("read direction bit wrong");

   property p_msb_first;
      @(posedge clk) disable iff (!rst_n)
      state == twm_pkg::S_SHIFT && quarter == 2'd2 && !rxMode |-> sdaOe == !txByte[7];
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("bit order wrong");

   property p_reg_byte;
      @(posedge clk) disable iff (!rst_n)
      $rose(step == twm_pkg::ST_REG) |-> txByte == regAddrL && state == twm_pkg::S_SHIFT;
   endproperty
   a_reg_byte: assert property (p_reg_byte) else $error("register byte not sent");

   property p_read_setup;
      @(posedge clk) disable iff (!rst_n)
      state == twm_pkg::S_START && step == twm_pkg::ST_ADDR_R |-> regSent;
   endproperty
   a_read_setup: assert property (p_read_setup) else $error("read without base address");

   property p_restart;
      @(posedge clk) disable iff (!rst_n)
      $rose(step == twm_pkg::ST_ADDR_R) |-> $past(state) == twm_pkg::S_ACK && state == twm_pkg::S_START;
   endproperty
   a_restart: assert property (p_restart) else $error("stop before repeated start");

   property p_cov_write;
      @(posedge clk) disable iff (!rst_n)
      done && !isRead && !nackErr;
   endproperty
   c_write: cover property (p_cov_write);

   property p_cov_read;
      @(posedge clk) disable iff (!rst_n)
      rdValid ##[1:400] done;
   endproperty
   c_read: cover property (p_cov_read);

   property p_cov_nack;
      @(posedge clk) disable iff (!rst_n)
      $rose(nackErr);
   endproperty
   c_nack: cover property (p_cov_nack);
endmodule // twm_master

/* File: common/twm_defs.svh */
// Constants for the two-wire register access master.
// Assumes a 25 MHz system clock.
`ifndef TWM_DEFS_SVH
`define TWM_DEFS_SVH
// Upper six bits of the slave address; the select level fills bit 0
`define TWM_SLAVE_ADDR_HI 6'h26
`define TWM_CLK_NS 40
// One quarter of a bus clock period
`define TWM_QUARTER_NS 80
`define TWM_QUARTER_CYC ((`TWM_QUARTER_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS)
`define TWM_FIFO_DEPTH 8
`define TWM_BYTE_W 8
`endif

/* File: common/twm_pkg.sv */
// Types for the two-wire register access master.
// Assumes nothing of its surroundings.
package twm_pkg;
   typedef enum logic [5:0] {
      S_IDLE  = 6'h01,
      S_START = 6'h02,
      S_SHIFT = 6'h04,
      S_ACK   = 6'h08,
      S_LOAD  = 6'h10,
      S_STOP  = 6'h20
   } twm_state_e;
   typedef enum logic [3:0] {
      ST_ADDR_W = 4'h1,
      ST_REG    = 4'h2,
      ST_DATA   = 4'h4,
      ST_ADDR_R = 4'h8
   } twm_step_e;
endpackage

/* File: src/twm_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
module twm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign outData = mem[rdPtr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
         inReady <= 1'b1;
         outValid <= 1'b0;
      end else begin
         if (push) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= rdPtr + 1'b1;
         end
         count <= next_count;
         inReady <= next_count != (AW+1)'(DEPTH);
         outValid <= next_count != '0;
      end
   end
endmodule // twm_fifo

/* File: dv/twm_slave_model.sv */
// Behavioural register slave standing on the far side of the two-wire master.
// Assumes open-drain lines resolved by the bench with pull-ups; oe high pulls low.
`timescale 1ns/1ps
module twm_slave_model #(
   parameter logic [7:0] TOP_REG = 8'h1F
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic addrSelect,
   input wire logic stretch,
   output logic sclOe,
   output logic sdaOe
);
   logic [7:0] mem [0:255];
   logic [7:0] ptr;
   logic [7:0] sh;
   logic startSeen;
   logic hostAck;

   initial begin
      sclOe = 1'b0;
      sdaOe = 1'b0;
      startSeen = 1'b0;
      ptr = 8'h00;
      foreach (mem[i]) mem[i] = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start, repeated start and stop restart the frame
   always @(negedge sda) if (scl === 1'b1) begin
      disable body;
      {sclOe, sdaOe} = 2'b00;
      startSeen = 1'b1;
   end
   always @(posedge sda) if (scl === 1'b1) begin
      disable body;
      {sclOe, sdaOe} = 2'b00;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic getByte();
      repeat (8) begin
         @(posedge scl);
         sh = {sh[6:0], sda};
      end
      @(negedge scl);
   endtask

   // Ack held through the ninth pulse; optional stretch for a slow answer
   task automatic giveAck(input logic ok);
      sdaOe = ok;
      @(negedge scl);
      sdaOe = 1'b0;
      if (stretch) begin
         sclOe = 1'b1;
         #600;
         sclOe = 1'b0;
      end
   endtask

   task automatic sendByte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         sdaOe = !v[i];
         @(negedge scl);
      end
      sdaOe = 1'b0;
      @(posedge scl);
      hostAck = !sda;
      @(negedge scl);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always begin : body
      wait (startSeen === 1'b1);
      startSeen = 1'b0;
      getByte();
      if (sh[7:1] !== {6'h26, addrSelect})
         forever @(posedge scl);
      giveAck(1'b1);
      if (sh[0] === 1'b0) begin
         getByte();
         if (sh > TOP_REG) begin
            giveAck(1'b0);
            forever @(posedge scl);
         end
         ptr = sh;
         giveAck(1'b1);
         forever begin
            getByte();
            mem[ptr] = sh;
            if (ptr < TOP_REG) ptr = ptr + 8'h01;
            giveAck(1'b1);
         end
      end
      hostAck = 1'b1;
      while (hostAck) begin
         sendByte(mem[ptr]);
         if (ptr < TOP_REG) ptr = ptr + 8'h01;
      end
      forever @(posedge scl);
   end
endmodule // twm_slave_model

/* File: dv/test_twm_master.sv */
// Self-checking bench for the two-wire master against a behavioural slave.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module test_twm_master;
   localparam logic [7:0] TOP = 8'h1F;
   logic clk, rst_n, cmdValid, cmdReady, cmdRead, cmdSelect, wrValid, wrReady;
   logic [7:0] cmdRegAddr, cmdCount, wrData, rdData;
   logic rdValid, done, nackErr, busy, sclOe, sdaOe, mSclOe, mSdaOe, addrSelect, stretch, sclDrive, sdaDrive;
   wire scl = !(sclOe | mSclOe);
   wire sda = !(sdaOe | mSdaOe);
   int errors, num_checks, cycles, starts, stops;
   logic [7:0] rdQ [$];

   twm_master dut (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead),
      .cmdSelect(cmdSelect), .cmdRegAddr(cmdRegAddr), .cmdCount(cmdCount), .wrData(wrData), .wrValid(wrValid),
      .wrReady(wrReady), .rdData(rdData), .rdValid(rdValid), .done(done), .nackErr(nackErr), .busy(busy),
      .sclIn(scl), .sclOut(sclDrive), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaDrive), .sdaOe(sdaOe));
   twm_slave_model #(.TOP_REG(TOP)) m (.scl(scl), .sda(sda), .addrSelect(addrSelect), .stretch(stretch),
      .sclOe(mSclOe), .sdaOe(mSdaOe));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(negedge sda) if (scl === 1'b1) starts++;
   always @(posedge sda) if (scl === 1'b1) stops++;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic push(input logic [7:0] b);
      @(negedge clk);
      wrData = b;
      wrValid = 1'b1;
      @(posedge clk);
      while (wrReady !== 1'b1) @(posedge clk);
      @(negedge clk);
      wrValid = 1'b0;
   endtask

   // Runs one command; ends with nack flag, frame counts and idle lines checked
   task automatic run(input logic rd, input logic sel, input logic [7:0] ra, input logic [7:0] n,
                      input logic expNack);
      @(negedge clk);
      {cmdRead, cmdSelect, cmdRegAddr, cmdCount} = {rd, sel, ra, n};
      cmdValid = 1'b1;
      starts = 0;
      stops = 0;
      @(posedge clk);
      while (cmdReady !== 1'b1) @(posedge clk);
      @(negedge clk);
      cmdValid = 1'b0;
      chk("busy", 8'h01, {7'h00, busy});
      rdQ = {};
      forever begin
         @(negedge clk);
         if (rdValid === 1'b1) rdQ.push_back(rdData);
         if (done === 1'b1) break;
      end
      @(negedge clk);
      chk("nackErr", {7'h00, expNack}, {7'h00, nackErr});
      chk("starts", (rd && !expNack) ? 8'h02 : 8'h01, starts[7:0]);
      chk("stops", 8'h01, stops[7:0]);
      chk("idle", 8'h03, {6'h00, scl, sda});
      chk("busy ready", 8'h01, {6'h00, busy, cmdReady});
      chk("pin level", 8'h00, {6'h00, sclDrive, sdaDrive});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_fill_write();
      stretch = 1'b1;
      for (int i = 0; i < 8; i++) push(8'h10 + i[7:0]);
      chk("wrReady full", 8'h00, {7'h00, wrReady});
      run(1'b0, 1'b0, 8'h03, 8'h08, 1'b0);
      for (int i = 0; i < 8; i++) chk("mem", 8'h10 + i[7:0], m.mem[8'h03 + i[7:0]]);
      chk("wrReady empty", 8'h01, {7'h00, wrReady});
      stretch = 1'b0;
   endtask

   task automatic t_read();
      run(1'b1, 1'b0, 8'h04, 8'h04, 1'b0);
      chk("rd count", 8'h04, 8'(rdQ.size()));
      for (int i = 0; i < 4; i++) chk("rdData", 8'h11 + i[7:0], rdQ[i]);
   endtask

   task automatic t_saturate();
      push(8'hA0);
      push(8'hA1);
      push(8'hA2);
      run(1'b0, 1'b0, TOP - 8'h01, 8'h03, 1'b0);
      chk("mem top-1", 8'hA0, m.mem[TOP - 8'h01]);
      chk("mem top", 8'hA2, m.mem[TOP]);
      run(1'b1, 1'b0, TOP - 8'h01, 8'h03, 1'b0);
      chk("rd sat 0", 8'hA0, rdQ[0]);
      chk("rd sat 1", 8'hA2, rdQ[1]);
      chk("rd sat 2", 8'hA2, rdQ[2]);
   endtask

   task automatic t_select();
      addrSelect = 1'b1;
      run(1'b0, 1'b0, 8'h05, 8'h00, 1'b1);
      run(1'b1, 1'b1, 8'h05, 8'h01, 1'b0);
      chk("rd sel", 8'h12, rdQ[0]);
      run(1'b0, 1'b1, 8'h07, 8'h00, 1'b0);
      chk("ptr", 8'h07, m.ptr);
      run(1'b1, 1'b1, 8'h07, 8'h00, 1'b0);
      chk("rd zero count", 8'h01, 8'(rdQ.size()));
      chk("rd zero", 8'h14, rdQ[0]);
      addrSelect = 1'b0;
   endtask

   task automatic t_bad_reg();
      push(8'h5A);
      run(1'b0, 1'b0, TOP + 8'h01, 8'h01, 1'b1);
      run(1'b0, 1'b0, 8'h02, 8'h01, 1'b0);
      chk("leftover", 8'h5A, m.mem[8'h02]);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {cmdValid, cmdRead, cmdSelect, cmdRegAddr, cmdCount, wrData, wrValid} = '0;
      {addrSelect, stretch, rst_n} = 3'b000;
      {errors, num_checks, cycles, starts, stops} = '0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      t_fill_write();
      t_read();
      t_saturate();
      t_select();
      t_bad_reg();
      stop_test();
   end
endmodule // test_twm_master
